//--- inc/udcs_if.sv
`timescale 1ns/100ps
interface udcs_if;
    logic req;
    logic we;
    logic [2:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;

    modport dev (input req, input we, input idx, input wdata, output rdata, output ack);
    modport ctl (output req, output we, output idx, output wdata, input rdata, input ack);
endinterface

//--- inc/udcs_pkg.sv
package udcs_pkg;
    // Register indices on the device's own access port.
    localparam logic [2:0] UDCS_IDX_SYSCTL = 3'h0;
    localparam logic [2:0] UDCS_IDX_PINSTAT = 3'h1;
    localparam logic [2:0] UDCS_IDX_EPIEN = 3'h2;
    localparam logic [2:0] UDCS_IDX_BUSCTL = 3'h3;
    localparam logic [2:0] UDCS_IDX_EPFLAG = 3'h4;
    localparam logic [2:0] UDCS_IDX_CLKCTL = 3'h5;
    // system_usb_control fields.
    localparam int UDCS_SYS_DIS = 6;
    localparam int UDCS_SYS_PDOFF = 5;
    localparam int UDCS_SYS_VLVL = 4;
    localparam int UDCS_SYS_RSVD = 1;
    localparam int UDCS_SYS_ESD = 0;
    // pin_and_noise_status fields.
    localparam int UDCS_ST_ODB_OUT = 7;
    localparam int UDCS_ST_ODA_OUT = 6;
    localparam int UDCS_ST_ODB_IN = 5;
    localparam int UDCS_ST_ODA_IN = 4;
    localparam int UDCS_ST_SE1 = 3;
    localparam int UDCS_ST_SE0 = 2;
    localparam int UDCS_ST_PU = 1;
    // bus_state_control fields.
    localparam int UDCS_BS_RSTCPU = 7;
    localparam int UDCS_BS_MODE_HI = 6;
    localparam int UDCS_BS_MODE_LO = 4;
    localparam int UDCS_BS_RESUME = 3;
    localparam int UDCS_BS_RST = 2;
    localparam int UDCS_BS_WAKE = 1;
    localparam int UDCS_BS_SUSPENDED_FLAG = 0;
    // engine_clock_control fields.
    localparam int UDCS_CK_LOWCUR = 4;
    localparam int UDCS_CK_GATE = 3;
    // Reset values.
    localparam logic [7:0] UDCS_RST_PINSTAT = 8'hc0;
    localparam logic [7:0] UDCS_RST_BUSCTL = 8'h80;
    localparam logic [7:0] UDCS_RST_ZERO = 8'h00;
    // Pin mode codes.
    localparam logic [2:0] UDCS_MODE_FLOAT = 3'h0;
    localparam logic [2:0] UDCS_MODE_OPENDRAIN = 3'h1;
    localparam logic [1:0] UDCS_MODE_USB_HI = 2'h1;
    // Engine tick divider: 100 MHz system clock down to the engine rate.
    localparam int UDCS_ENGINE_DIV = 8;
    localparam logic [3:0] UDCS_ENGINE_DIV_LAST = 4'(UDCS_ENGINE_DIV - 1);
    // Controller APB map (byte addresses).
    localparam logic [11:0] UDCS_APB_CMD = 12'h000;
    localparam logic [11:0] UDCS_APB_STATUS = 12'h004;
    localparam int UDCS_CMD_IDX_LO = 0;
    localparam int UDCS_CMD_DATA_LO = 8;
    localparam int UDCS_CMD_WRITE = 16;
    localparam int UDCS_CMD_GO = 17;
    localparam int UDCS_CMD_SUSPWATCH = 18;
    localparam int UDCS_STAT_BUSY = 0;
    localparam int UDCS_STAT_DATA_LO = 8;

    typedef enum logic [1:0] {
        UDCS_IDLE = 2'b00,
        UDCS_ISSUE = 2'b01,
        UDCS_DONE = 2'b11
    } udcs_ctl_state_t;
endpackage

//--- rtl/udcs_ctl.sv
`timescale 1ns/100ps
module udcs_ctl
    import udcs_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error, never raised.
    udcs_if.ctl acc // Device register access port.
);
    udcs_ctl_state_t state;
    logic [2:0] cmd_idx;
    logic [7:0] cmd_data;
    logic cmd_write;
    logic suspended_flag_watch;
    logic [7:0] rd_data;
    logic apb_wr;
    logic go;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign apb_wr = psel && penable && pwrite && paddr == UDCS_APB_CMD;
    assign go = apb_wr && pwdata[UDCS_CMD_GO] && state == UDCS_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_idx <= 3'h0;
            cmd_data <= 8'h00;
            cmd_write <= 1'b0;
            suspended_flag_watch <= 1'b0;
        end else if (apb_wr && state == UDCS_IDLE) begin
            cmd_idx <= pwdata[UDCS_CMD_IDX_LO +: 3];
            cmd_data <= pwdata[UDCS_CMD_DATA_LO +: 8];
            cmd_write <= pwdata[UDCS_CMD_WRITE];
            suspended_flag_watch <= pwdata[UDCS_CMD_SUSPWATCH];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= UDCS_IDLE;
            rd_data <= 8'h00;
        end else begin
            case (state)
                UDCS_IDLE: begin
                    if (go) begin
                        state <= UDCS_ISSUE;
                    end
                end
                UDCS_ISSUE: begin
                    if (acc.ack) begin
                        rd_data <= acc.rdata;
                        state <= UDCS_DONE;
                    end
                end
                UDCS_DONE: state <= UDCS_IDLE;
                default: state <= UDCS_IDLE;
            endcase
        end
    end

    // The request is held until the device acknowledges it.
    always_comb begin
        acc.req = (state == UDCS_ISSUE);
        acc.we = cmd_write;
        acc.idx = cmd_idx;
        acc.wdata = cmd_data;
        if (cmd_idx == UDCS_IDX_SYSCTL) begin
            acc.wdata[UDCS_SYS_RSVD] = 1'b0;
        end
        if (cmd_idx == UDCS_IDX_CLKCTL && suspended_flag_watch) begin
            acc.wdata[UDCS_CK_GATE] = 1'b1;
            acc.wdata[UDCS_CK_LOWCUR] = 1'b0;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            if (paddr == UDCS_APB_STATUS) begin
                prdata[UDCS_STAT_BUSY] = (state != UDCS_IDLE);
                prdata[UDCS_STAT_DATA_LO +: 8] = rd_data;
            end else if (paddr == UDCS_APB_CMD) begin
                prdata[UDCS_CMD_IDX_LO +: 3] = cmd_idx;
                prdata[UDCS_CMD_DATA_LO +: 8] = cmd_data;
                prdata[UDCS_CMD_WRITE] = cmd_write;
                prdata[UDCS_CMD_SUSPWATCH] = suspended_flag_watch;
            end
        end
    end
endmodule

//--- rtl/udcs_device.sv
// What this block does
// - Disable bit switches the whole engine off
// - Sense pull-down on unless its bit set
// - Status bit shows sense pin level
// - Engine sets discharge flag; software clears it
// - Two open-drain output bits, reset to one
// - Two bits read open-drain pin levels
// - Engine sets sticky SE1 noise flag
// - Engine sets sticky SE0 noise flag
// - Bit enables weak data line pull-ups
// - Eight endpoint interrupt enables, reset to zero
// - Bus reset resets CPU when bit set
// - Three-bit mode selects pin behaviour
// - Resume sets flag and wakes the CPU
// - Leaving suspend clears suspend, then resume
// - Software enables clock, disables low-current, for suspend
// - Engine alone sets, clears bus reset flag
// - Wake bit held one engine tick signals host
// - Suspend flag; interrupt on rising edge only
// - Access sets flag; interrupt if enabled, stack free
// - Software clears endpoint flags; hardware never does
// - Reserved control bit kept at zero
// - Clock gate bit gates engine clock
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
module udcs_device
    import udcs_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    udcs_if.dev acc, // Register access port.
    input wire logic vsense_in, // Bus supply sense pin level.
    input wire logic opendrain_a_in, // Open-drain pin A level.
    input wire logic opendrain_b_in, // Open-drain pin B level.
    input wire logic bus_reset_det, // Engine sees bus reset (level).
    input wire logic suspend_det, // Engine sees bus idle suspend (level).
    input wire logic resume_det, // Engine sees resume signalling (pulse).
    input wire logic discharge_det, // Discharge event (pulse).
    input wire logic se1_noise_det, // SE1 noise (pulse).
    input wire logic se0_noise_det, // SE0 noise (pulse).
    input wire logic [7:0] ep_access, // Host accessed endpoint n (pulse).
    input wire logic stack_full, // CPU call stack is full.
    output logic engine_on, // Engine enabled.
    output logic engine_tick, // Gated engine clock enable pulse.
    output logic vsense_pulldown_on, // Pull-down on sense pin.
    output logic opendrain_a_o, // Open-drain A output value.
    output logic opendrain_a_oe_n, // Open-drain A drive, low drives.
    output logic opendrain_b_o, // Open-drain B output value.
    output logic opendrain_b_oe_n, // Open-drain B drive, low drives.
    output logic opendrain_pullups_on, // Pull-ups on open-drain pins.
    output logic data_line_weak_high, // Weak pull-ups on data lines.
    output logic regulator_on, // Regulator output enabled.
    output logic regulator_tied_supply, // Regulator output tied to supply.
    output logic usb_pins_on, // Pins act as data plus and minus.
    output logic cpu_reset_req, // Request whole-CPU reset (pulse).
    output logic cpu_wake_irq, // Resume wake-up interrupt (pulse).
    output logic usb_irq, // USB event interrupt (pulse).
    output logic endpoint_irq, // Endpoint request level.
    output logic remote_wake_out // Wake-up signalling to host (pulse).
);
    logic [7:0] sysctl;
    logic [7:0] pinstat;
    logic [7:0] epien;
    logic [7:0] busctl;
    logic [7:0] epflag;
    logic [7:0] clkctl;
    logic [3:0] div_cnt;
    logic div_pulse;
    logic bus_rst_d;
    logic wake_done;
    logic [7:0] rd_mux;
    logic wr;
    logic [2:0] mode;

    assign wr = acc.req && acc.we && !acc.ack;
    assign mode = busctl[UDCS_BS_MODE_HI:UDCS_BS_MODE_LO];
    assign engine_on = !sysctl[UDCS_SYS_DIS];

    // Engine rate divider; the engine only runs while enabled and gated on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 4'h0;
        end else if (div_cnt == UDCS_ENGINE_DIV_LAST) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end
    assign div_pulse = (div_cnt == UDCS_ENGINE_DIV_LAST);
    assign engine_tick = div_pulse && clkctl[UDCS_CK_GATE] && engine_on;

    // Register access answers one cycle after the request is seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc.ack <= 1'b0;
            acc.rdata <= 8'h00;
        end else begin
            acc.ack <= acc.req && !acc.ack;
            acc.rdata <= rd_mux;
        end
    end

    always_comb begin
        case (acc.idx)
            UDCS_IDX_SYSCTL: rd_mux = sysctl;
            UDCS_IDX_PINSTAT: rd_mux = pinstat;
            UDCS_IDX_EPIEN: rd_mux = epien;
            UDCS_IDX_BUSCTL: rd_mux = busctl;
            UDCS_IDX_EPFLAG: rd_mux = epflag;
            UDCS_IDX_CLKCTL: rd_mux = clkctl;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysctl <= UDCS_RST_ZERO;
        end else begin
            if (wr && acc.idx == UDCS_IDX_SYSCTL) begin
                sysctl[UDCS_SYS_DIS] <= acc.wdata[UDCS_SYS_DIS];
                sysctl[UDCS_SYS_PDOFF] <= acc.wdata[UDCS_SYS_PDOFF];
                sysctl[UDCS_SYS_RSVD] <= acc.wdata[UDCS_SYS_RSVD];
            end
            sysctl[UDCS_SYS_VLVL] <= vsense_in;
            // A discharge event in the clearing cycle still lands.
            sysctl[UDCS_SYS_ESD] <= ((wr && acc.idx == UDCS_IDX_SYSCTL)
                ? acc.wdata[UDCS_SYS_ESD] : sysctl[UDCS_SYS_ESD])
                | (discharge_det && engine_on);
        end
    end
    assign vsense_pulldown_on = !sysctl[UDCS_SYS_PDOFF];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pinstat <= UDCS_RST_PINSTAT;
        end else begin
            if (wr && acc.idx == UDCS_IDX_PINSTAT) begin
                pinstat[UDCS_ST_ODB_OUT] <= acc.wdata[UDCS_ST_ODB_OUT];
                pinstat[UDCS_ST_ODA_OUT] <= acc.wdata[UDCS_ST_ODA_OUT];
                pinstat[UDCS_ST_PU] <= acc.wdata[UDCS_ST_PU];
            end
            pinstat[UDCS_ST_ODB_IN] <= opendrain_b_in;
            pinstat[UDCS_ST_ODA_IN] <= opendrain_a_in;
            pinstat[UDCS_ST_SE1] <= ((wr && acc.idx == UDCS_IDX_PINSTAT)
                ? acc.wdata[UDCS_ST_SE1] : pinstat[UDCS_ST_SE1])
                | (se1_noise_det && engine_on);
            pinstat[UDCS_ST_SE0] <= ((wr && acc.idx == UDCS_IDX_PINSTAT)
                ? acc.wdata[UDCS_ST_SE0] : pinstat[UDCS_ST_SE0])
                | (se0_noise_det && engine_on);
        end
    end
    assign data_line_weak_high = pinstat[UDCS_ST_PU];

    // Pin mode decode; codes 100 to 111 leave every pin floating.
    always_comb begin
        regulator_tied_supply = (mode == UDCS_MODE_OPENDRAIN);
        opendrain_pullups_on = (mode == UDCS_MODE_OPENDRAIN);
        regulator_on = (mode[2:1] == UDCS_MODE_USB_HI);
        usb_pins_on = (mode[2:1] == UDCS_MODE_USB_HI);
    end
    assign opendrain_a_o = 1'b0;
    assign opendrain_b_o = 1'b0;
    assign opendrain_a_oe_n = !(opendrain_pullups_on && !pinstat[UDCS_ST_ODA_OUT]);
    assign opendrain_b_oe_n = !(opendrain_pullups_on && !pinstat[UDCS_ST_ODB_OUT]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            epien <= UDCS_RST_ZERO;
        end else if (wr && acc.idx == UDCS_IDX_EPIEN) begin
            epien <= acc.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clkctl <= UDCS_RST_ZERO;
        end else if (wr && acc.idx == UDCS_IDX_CLKCTL) begin
            clkctl[UDCS_CK_GATE] <= acc.wdata[UDCS_CK_GATE];
            clkctl[UDCS_CK_LOWCUR] <= acc.wdata[UDCS_CK_LOWCUR];
        end
    end

    // Endpoint flags are only ever cleared by a software write.
    for (genvar n = 0; n < 8; n++) begin : g_ep
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                epflag[n] <= 1'b0;
            end else begin
                epflag[n] <= ((wr && acc.idx == UDCS_IDX_EPFLAG) ? acc.wdata[n] : epflag[n])
                    | (ep_access[n] && engine_on);
            end
        end
    end
    assign endpoint_irq = |(epflag & epien);

    // Bus state: the engine owns the suspend, resume and reset indications.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busctl <= UDCS_RST_BUSCTL;
            bus_rst_d <= 1'b0;
        end else begin
            bus_rst_d <= bus_reset_det && engine_on;
            if (wr && acc.idx == UDCS_IDX_BUSCTL) begin
                busctl[UDCS_BS_RSTCPU] <= acc.wdata[UDCS_BS_RSTCPU];
                busctl[UDCS_BS_MODE_HI:UDCS_BS_MODE_LO] <=
                    acc.wdata[UDCS_BS_MODE_HI:UDCS_BS_MODE_LO];
                busctl[UDCS_BS_WAKE] <= acc.wdata[UDCS_BS_WAKE];
            end
            busctl[UDCS_BS_RST] <= bus_reset_det && engine_on;
            // Suspend is seen only while the engine clock runs.
            if (suspend_det && engine_on && clkctl[UDCS_CK_GATE]) begin
                busctl[UDCS_BS_SUSPENDED_FLAG] <= 1'b1;
            end else if (busctl[UDCS_BS_SUSPENDED_FLAG] && !suspend_det) begin
                busctl[UDCS_BS_SUSPENDED_FLAG] <= 1'b0;
            end
            if (resume_det && engine_on) begin
                busctl[UDCS_BS_RESUME] <= 1'b1;
            end else if (!busctl[UDCS_BS_SUSPENDED_FLAG] && !suspend_det) begin
                busctl[UDCS_BS_RESUME] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_reset_req <= 1'b0;
            cpu_wake_irq <= 1'b0;
            usb_irq <= 1'b0;
        end else begin
            cpu_reset_req <= bus_reset_det && engine_on && !bus_rst_d
                && busctl[UDCS_BS_RSTCPU];
            cpu_wake_irq <= resume_det && engine_on;
            usb_irq <= (bus_reset_det && engine_on && !bus_rst_d)
                || (suspend_det && engine_on && clkctl[UDCS_CK_GATE]
                    && !busctl[UDCS_BS_SUSPENDED_FLAG])
                || (|(ep_access & epien) && engine_on && !stack_full);
        end
    end

    // The wake command is sampled on the engine tick, once per high period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_wake_out <= 1'b0;
            wake_done <= 1'b0;
        end else begin
            remote_wake_out <= engine_tick && busctl[UDCS_BS_WAKE] && !wake_done;
            if (!busctl[UDCS_BS_WAKE]) begin
                wake_done <= 1'b0;
            end else if (engine_tick) begin
                wake_done <= 1'b1;
            end
        end
    end
endmodule

//--- tb/udcs_checker.sv
`timescale 1ns/100ps
module udcs_checker
    import udcs_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Reset, active low.
    input wire logic req, // Link request.
    input wire logic we, // Link direction.
    input wire logic [2:0] idx, // Register index.
    input wire logic [7:0] wdata, // Write data.
    input wire logic [7:0] rdata, // Read data.
    input wire logic ack // Link answer.
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] sh_sys;
    logic [7:0] sh_pin;
    logic [7:0] sh_en;
    logic [7:0] sh_bus;
    wire rd = ack && !we;
    // Shadows keep only what software wrote; status bits are masked where compared.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_sys <= UDCS_RST_ZERO;
            sh_pin <= UDCS_RST_PINSTAT;
            sh_en <= UDCS_RST_ZERO;
            sh_bus <= UDCS_RST_BUSCTL;
        end else if (ack && we) begin
            case (idx)
                UDCS_IDX_SYSCTL: sh_sys <= wdata;
                UDCS_IDX_PINSTAT: sh_pin <= wdata;
                UDCS_IDX_EPIEN: sh_en <= wdata;
                UDCS_IDX_BUSCTL: sh_bus <= wdata;
                default: ;
            endcase
        end
    end
    a_ack_after_req: assert property (req && !ack |=> ack)
        else $error("no answer one cycle after request");
    a_ack_one_cycle: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    a_req_released: assert property (ack |=> !req)
        else $error("request not dropped after answer");
    a_no_stray_ack: assert property (!req |=> !ack)
        else $error("answer without request");
    a_req_held: assert property (req && !ack |=> req && $stable(idx) && $stable(we)
        && $stable(wdata)) else $error("request changed before answer");
    a_rsvd_zero: assert property (req && we && idx == UDCS_IDX_SYSCTL |-> !wdata[UDCS_SYS_RSVD])
        else $error("reserved control bit written as one");
    a_sys_bits: assert property (rd && idx == UDCS_IDX_SYSCTL |-> rdata[6:5] == sh_sys[6:5])
        else $error("system control bits read back wrong");
    a_pin_bits: assert property (rd && idx == UDCS_IDX_PINSTAT |->
        {rdata[7:6], rdata[1]} == {sh_pin[7:6], sh_pin[1]}) else $error("pin bits read back wrong");
    a_enable_bits: assert property (rd && idx == UDCS_IDX_EPIEN |-> rdata == sh_en)
        else $error("endpoint enables read back wrong");
    a_bus_bits: assert property (rd && idx == UDCS_IDX_BUSCTL |-> rdata[7:4] == sh_bus[7:4])
        else $error("bus control bits read back wrong");
    c_write: cover property (ack && we);
    c_bus_read: cover property (rd && idx == UDCS_IDX_BUSCTL);
    c_flag_write: cover property (ack && we && idx == UDCS_IDX_EPFLAG);
endmodule

//--- tb/usb_device_control_status_tb.sv
`timescale 1ns/100ps
module usb_device_control_status_tb;
    import udcs_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr;
    logic vs_in = 1'b0, oda_in = 1'b0, odb_in = 1'b0, bus_rst = 1'b0, suspended_flag = 1'b0;
    logic stack_full = 1'b0;
    logic [3:0] evp = 4'h0;
    logic [7:0] ep_acc = 8'h00;
    logic [7:0] d;
    logic [7:0] rv [6] = '{8'h00, 8'hc0, 8'h00, 8'h80, 8'h00, 8'h00};
    logic eng_on, tick, pd_on, oda_o, oda_oe_n, odb_o, odb_oe_n, od_pu;
    logic weak_hi, reg_on, reg_tied, pins_on, cpu_rst, wake_irq, usb_irq, ep_irq, rwake;
    int bad_count = 0, tests_run = 0;
    int n_irq = 0, n_cpu = 0, n_wake = 0, n_rw = 0, n_tick = 0;
    udcs_if lnk();
    udcs_device u_udcs_device (.pclk(pclk), .presetn(presetn), .acc(lnk.dev),
        .vsense_in(vs_in), .opendrain_a_in(oda_in), .opendrain_b_in(odb_in),
        .bus_reset_det(bus_rst), .suspend_det(suspended_flag), .resume_det(evp[3]),
        .discharge_det(evp[2]), .se1_noise_det(evp[1]), .se0_noise_det(evp[0]),
        .ep_access(ep_acc), .stack_full(stack_full), .engine_on(eng_on), .engine_tick(tick),
        .vsense_pulldown_on(pd_on), .opendrain_a_o(oda_o), .opendrain_a_oe_n(oda_oe_n),
        .opendrain_b_o(odb_o), .opendrain_b_oe_n(odb_oe_n), .opendrain_pullups_on(od_pu),
        .data_line_weak_high(weak_hi), .regulator_on(reg_on), .regulator_tied_supply(reg_tied),
        .usb_pins_on(pins_on), .cpu_reset_req(cpu_rst), .cpu_wake_irq(wake_irq),
        .usb_irq(usb_irq), .endpoint_irq(ep_irq), .remote_wake_out(rwake));
    udcs_ctl u_udcs_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acc(lnk.ctl));
    udcs_checker u_udcs_checker (.pclk(pclk), .presetn(presetn), .req(lnk.req), .we(lnk.we),
        .idx(lnk.idx), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack));
    always #5 pclk = ~pclk;
    // Pulses are counted on the falling edge, so a count never races the edge that clears it.
    always @(negedge pclk) begin
        n_irq += usb_irq;
        n_cpu += cpu_rst;
        n_wake += wake_irq;
        n_rw += rwake;
        n_tick += tick;
    end
    task summarize;
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task dev(input logic wr, input logic [2:0] i, input logic [7:0] wd, output logic [7:0] rd);
        logic [31:0] q;
        apb(1'b1, UDCS_APB_CMD, {13'h0, 1'b0, 1'b1, wr, wd, 5'h00, i}, q);
        do apb(1'b0, UDCS_APB_STATUS, 32'h0, q); while (q[UDCS_STAT_BUSY] !== 1'b0);
        rd = q[15:8];
    endtask
    task pulse(input logic [3:0] e, input logic [7:0] ep);
        @(posedge pclk);
        evp <= e;
        ep_acc <= ep;
        @(posedge pclk);
        evp <= 4'h0;
        ep_acc <= 8'h00;
        repeat (3) @(posedge pclk);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("reset outputs", {eng_on, pd_on, oda_oe_n, odb_oe_n, reg_on, pins_on, ep_irq}, 7'h78);
        for (int i = 0; i < 6; i++) begin
            dev(1'b0, i[2:0], 8'h00, d);
            check("reset value", d, rv[i]);
        end
        apb(1'b1, 12'h00c, 32'hffff_ffff, r);
        apb(1'b0, 12'h00c, 32'h0, r);
        check("unmapped read", r, 32'h0);
        check("slave error", pslverr, 1'b0);
        dev(1'b1, UDCS_IDX_SYSCTL, 8'h60, d);
        check("engine and pull-down off", {eng_on, pd_on}, 2'b00);
        pulse(4'b0111, 8'h01);
        dev(1'b1, UDCS_IDX_SYSCTL, 8'h02, d);
        dev(1'b0, UDCS_IDX_SYSCTL, 8'h00, d);
        check("system control", {eng_on, pd_on, d}, {2'b11, 8'h00});
        vs_in <= 1'b1;
        oda_in <= 1'b1;
        dev(1'b0, UDCS_IDX_SYSCTL, 8'h00, d);
        check("sense level", d, 8'h10);
        dev(1'b0, UDCS_IDX_PINSTAT, 8'h00, d);
        check("pin levels", d, 8'hd0);
        vs_in <= 1'b0;
        odb_in <= 1'b1;
        oda_in <= 1'b0;
        pulse(4'b0111, 8'h00);
        dev(1'b0, UDCS_IDX_SYSCTL, 8'h00, d);
        check("discharge flag", d, 8'h01);
        dev(1'b0, UDCS_IDX_PINSTAT, 8'h00, d);
        check("noise flags", d, 8'hec);
        dev(1'b1, UDCS_IDX_SYSCTL, 8'h00, d);
        dev(1'b1, UDCS_IDX_PINSTAT, 8'hc0, d);
        dev(1'b0, UDCS_IDX_PINSTAT, 8'h00, d);
        check("noise flags cleared", d, 8'he0);
        for (int m = 0; m < 8; m++) begin
            dev(1'b1, UDCS_IDX_BUSCTL, {1'b1, m[2:0], 4'h0}, d);
            check("pin mode", {reg_on, pins_on, reg_tied, od_pu},
                {m[2:1] == 2'b01, m[2:1] == 2'b01, m == 1, m == 1});
        end
        dev(1'b1, UDCS_IDX_BUSCTL, 8'h90, d);
        dev(1'b1, UDCS_IDX_PINSTAT, 8'h82, d);
        check("open-drain drive", {oda_oe_n, odb_oe_n, oda_o, odb_o, weak_hi}, 5'b01001);
        dev(1'b1, UDCS_IDX_BUSCTL, 8'hc0, d);
        check("open-drain floating", {oda_oe_n, odb_oe_n}, 2'b11);
        dev(1'b1, UDCS_IDX_PINSTAT, 8'hc0, d);
        dev(1'b1, UDCS_IDX_EPIEN, 8'h04, d);
        n_irq = 0;
        pulse(4'h0, 8'h04);
        check("enabled endpoint", {n_irq[3:0], ep_irq}, 5'h03);
        pulse(4'h0, 8'h20);
        stack_full <= 1'b1;
        pulse(4'h0, 8'h04);
        stack_full <= 1'b0;
        check("masked endpoint", n_irq, 1);
        repeat (20) @(posedge pclk);
        dev(1'b0, UDCS_IDX_EPFLAG, 8'h00, d);
        check("endpoint flags", d, 8'h24);
        dev(1'b1, UDCS_IDX_EPFLAG, 8'h00, d);
        check("endpoint request", ep_irq, 1'b0);
        dev(1'b1, UDCS_IDX_EPIEN, 8'h00, d);
        n_irq = 0;
        bus_rst <= 1'b1;
        repeat (4) @(posedge pclk);
        dev(1'b0, UDCS_IDX_BUSCTL, 8'h00, d);
        check("bus reset seen", d[UDCS_BS_RST], 1'b1);
        bus_rst <= 1'b0;
        dev(1'b0, UDCS_IDX_BUSCTL, 8'h00, d);
        check("bus reset gone", {d[UDCS_BS_RST], n_cpu[3:0], n_irq[3:0]}, 9'h011);
        dev(1'b1, UDCS_IDX_BUSCTL, 8'h40, d);
        bus_rst <= 1'b1;
        repeat (4) @(posedge pclk);
        bus_rst <= 1'b0;
        check("cpu kept running", n_cpu, 1);
        apb(1'b1, UDCS_APB_CMD, {13'h0, 1'b1, 1'b1, 1'b1, 8'h10, 5'h00, UDCS_IDX_CLKCTL}, r);
        do apb(1'b0, UDCS_APB_STATUS, 32'h0, r); while (r[UDCS_STAT_BUSY] !== 1'b0);
        dev(1'b0, UDCS_IDX_CLKCTL, 8'h00, d);
        check("suspend watch clock", d, 8'h08);
        dev(1'b1, UDCS_IDX_CLKCTL, 8'h08, d);
        n_tick = 0;
        repeat (32) @(posedge pclk);
        check("engine ticks", n_tick, 4);
        n_irq = 0;
        suspended_flag <= 1'b1;
        repeat (12) @(posedge pclk);
        dev(1'b0, UDCS_IDX_BUSCTL, 8'h00, d);
        check("suspend", {d[UDCS_BS_SUSPENDED_FLAG], n_irq[3:0]}, 5'h11);
        pulse(4'b1000, 8'h00);
        dev(1'b0, UDCS_IDX_BUSCTL, 8'h00, d);
        check("resume", {d[UDCS_BS_RESUME], n_wake[3:0]}, 5'h11);
        suspended_flag <= 1'b0;
        repeat (4) @(posedge pclk);
        dev(1'b0, UDCS_IDX_BUSCTL, 8'h00, d);
        check("left suspend", {d[UDCS_BS_RESUME], d[UDCS_BS_SUSPENDED_FLAG]}, 2'b00);
        dev(1'b1, UDCS_IDX_BUSCTL, 8'h42, d);
        repeat (20) @(posedge pclk);
        dev(1'b1, UDCS_IDX_BUSCTL, 8'h40, d);
        check("remote wake", n_rw, 1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        dev(1'b0, UDCS_IDX_BUSCTL, 8'h00, d);
        check("bus control after reset", d, UDCS_RST_BUSCTL);
        summarize();
    end
    initial begin
        #100us;
        bad_count++;
        summarize();
    end
endmodule
